// ===== cfg_pkg.sv
package cfg_pkg;

	// ----------------------------------------------------------------
	// Message codes
	// ----------------------------------------------------------------
	localparam logic [7:0]  CMD_ENTER     = 8'hA0;
	localparam logic [7:0]  CMD_LEAVE     = 8'h80;
	localparam logic [7:0]  CMD_ADDR_RD   = 8'h1C;
	localparam logic [7:0]  CMD_ADDR_WR   = 8'h5C;
	localparam logic [7:0]  CMD_REV       = 8'hB0;
	localparam logic [2:0]  GRP_READ      = 3'h0;
	localparam logic [2:0]  GRP_WRITE     = 3'h2;
	localparam int          MSG_DATA_BYTES = 3;

	// ----------------------------------------------------------------
	// Configuration memory and slave address
	// ----------------------------------------------------------------
	localparam int          MEM_AW        = 5;
	localparam int          MEM_DW        = 16;
	localparam logic [4:0]  ADDR_WORD     = 5'h1C;
	localparam logic [15:0] ADDR_WORD_RST = 16'h0028;
	localparam logic [6:0]  DEF_ADDR      = 7'h28;

	// ----------------------------------------------------------------
	// Response byte fields
	// ----------------------------------------------------------------
	localparam logic [1:0]  ST_SESSION    = 2'h2;
	localparam logic [1:0]  ST_STALE      = 2'h1;
	localparam logic [1:0]  RES_BUSY      = 2'h0;
	localparam logic [1:0]  RES_ACK       = 2'h1;
	localparam logic [1:0]  RES_NACK      = 2'h2;
	localparam logic [7:0]  IDLE_BYTE     = 8'hFF;

	// ----------------------------------------------------------------
	// Timing, 25 MHz clock
	// ----------------------------------------------------------------
	localparam int          CLK_NS        = 40;
	localparam int          WINDOW_NS     = 10_000_000;
	localparam int          RESP_NS       = 100_000;
	localparam int          WRITE_NS      = 12_000_000;
	localparam int          WINDOW_CYC    = WINDOW_NS / CLK_NS;
	localparam int          RESP_CYC      = RESP_NS / CLK_NS;
	localparam int          WRITE_CYC     = WRITE_NS / CLK_NS;
	localparam int          CNT_W         = 19;

endpackage : cfg_pkg

// ===== cfg_mem_if.sv
`timescale 1ns/1ns
// Port between the interpreter and its configuration memory.
interface cfg_mem_if #(
	parameter int AW = 5,
	parameter int DW = 16
);
	logic          we;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;

	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem  (input we, input addr, input wdata, output rdata);
endinterface : cfg_mem_if

// ===== cfg_mem.sv
`timescale 1ns/1ns
module cfg_mem #(
	parameter int              AW       = 5,
	parameter int              DW       = 16,
	parameter logic [4:0]      RST_ADDR = 5'h1C,
	parameter logic [15:0]     RST_VAL  = 16'h0028
)(
	input  wire logic   clk,
	input  wire logic   rst_n,
	input  wire logic   ce,
	cfg_mem_if.mem      port
);
	logic [DW-1:0] words_r [2**AW];

	// Words reset to zero except the address word; read data is registered.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2**AW; i++) begin
				words_r[i] <= (i == int'(RST_ADDR)) ? RST_VAL : '0;
			end
			port.rdata <= '0;
		end else if (ce) begin
			if (port.we) begin
				words_r[port.addr] <= port.wdata;
			end
			port.rdata <= words_r[port.addr];
		end
	end
endmodule : cfg_mem

// ===== cfg_cmd_top.sv
`timescale 1ns/1ns
module cfg_cmd_top
	import cfg_pkg::*;
#(
	parameter int          WINDOW_CYCLES = WINDOW_CYC,
	parameter int          WRITE_CYCLES  = WRITE_CYC,
	parameter int          RESP_CYCLES   = RESP_CYC,
	parameter logic [15:0] REVISION      = 16'h0001  // Arbitrary value.
)(
	input  wire logic       MCLK,
	input  wire logic       RST_N,
	input  wire logic       CE,
	input  wire logic       SCL,
	input  wire logic       SDA_IN,
	input  wire logic [2:0] MEM_FAULT,
	output logic            SDA_OUT,
	output logic            SDA_OE,
	output logic            CONFIG_SESSION,
	output logic [6:0]      BUS_ADDR
);

	// ----------------------------------------------------------------
	// Pin synchronisers and bus conditions
	// ----------------------------------------------------------------
	logic [1:0] scl_q, sda_q;
	logic [1:0] flt_q0, flt_q1, flt_q2;
	logic       scl_d, sda_d;
	wire        scl_s = scl_q[1];
	wire        sda_s = sda_q[1];

	// Two stages per pin, then one more stage on SCL and SDA for edge detection.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			scl_q  <= 2'h3;
			sda_q  <= 2'h3;
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
			flt_q0 <= 2'h0;
			flt_q1 <= 2'h0;
			flt_q2 <= 2'h0;
		end else if (CE) begin
			scl_q  <= {scl_q[0], SCL};
			sda_q  <= {sda_q[0], SDA_IN};
			scl_d  <= scl_s;
			sda_d  <= sda_s;
			flt_q0 <= {flt_q0[0], MEM_FAULT[0]};
			flt_q1 <= {flt_q1[0], MEM_FAULT[1]};
			flt_q2 <= {flt_q2[0], MEM_FAULT[2]};
		end
	end

	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	// ----------------------------------------------------------------
	// Slave port state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_WBYTE, S_RBYTE, S_RACK, S_RNEXT} i2c_st_t;

	i2c_st_t    st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r, tx_r, cmd_r, dhi_r, dlo_r;
	logic [2:0] byte_r;
	logic       rw_r, oe_r, hit_r, go_r;
	logic [6:0] active_addr_r, pending_addr_r;
	logic       session_r;
	logic [CNT_W-1:0] busy_r, win_r;
	logic [1:0] result_r;
	logic       cfg_err_r, rd_pend_r;
	logic [15:0] rdata_r;

	cfg_mem_if #(.AW(MEM_AW), .DW(MEM_DW)) mif ();

	// Response byte: session status, plus diagnostics and result while in session, busy while counting.
	wire       busy      = (busy_r != '0);
	wire [3:0] diag      = {cfg_err_r, flt_q2[1], flt_q1[1], flt_q0[1]};
	wire [1:0] res_code  = busy ? RES_BUSY : result_r;
	wire [7:0] resp_byte = session_r ? {ST_SESSION, diag, res_code}
	                                 : {ST_STALE, 6'h00};
	wire [7:0] tx_sel    = (byte_r == 3'd0) ? resp_byte :
	                       (byte_r == 3'd1) ? rdata_r[15:8] :
	                       (byte_r == 3'd2) ? rdata_r[7:0] : IDLE_BYTE;
	wire       addr_hit  = (sh_r[7:1] == active_addr_r);
	wire       msg_full  = (byte_r == 3'(MSG_DATA_BYTES));

	// Bit-level slave: samples on SCL rise, drives SDA after SCL fall.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			st_r  <= S_IDLE;
			bit_r <= '0;
			sh_r  <= '0;
			tx_r  <= '0;
			cmd_r <= '0;
			dhi_r <= '0;
			dlo_r <= '0;
			byte_r <= '0;
			rw_r  <= 1'b0;
			oe_r  <= 1'b0;
			hit_r <= 1'b0;
			go_r  <= 1'b0;
		end else if (CE) begin
			go_r <= 1'b0;
			if (start_c) begin
				st_r   <= S_ADDR;
				bit_r  <= '0;
				byte_r <= '0;
				oe_r   <= 1'b0;
				hit_r  <= 1'b0;
			end else if (stop_c) begin
				st_r <= S_IDLE;
				oe_r <= 1'b0;
				go_r <= hit_r & ~rw_r & msg_full;
			end else begin
				case (st_r)
					S_ADDR, S_WBYTE: begin
						if (scl_rise) begin
							sh_r  <= {sh_r[6:0], sda_s};
							bit_r <= bit_r + 4'd1;
						end else if (scl_fall && bit_r == 4'd8) begin
							bit_r <= '0;
							if (st_r == S_ADDR) begin
								rw_r  <= sh_r[0];
								hit_r <= addr_hit;
								oe_r  <= addr_hit;
								st_r  <= addr_hit ? S_ACK : S_IDLE;
							end else begin
								if (byte_r == 3'd0) cmd_r <= sh_r;
								if (byte_r == 3'd1) dhi_r <= sh_r;
								if (byte_r == 3'd2) dlo_r <= sh_r;
								if (!byte_r[2]) byte_r <= byte_r + 3'd1;
								oe_r <= 1'b1;
								st_r <= S_ACK;
							end
						end
					end
					S_ACK: begin
						if (scl_fall) begin
							if (rw_r) begin
								tx_r <= tx_sel;
								oe_r <= ~tx_sel[7];
								st_r <= S_RBYTE;
							end else begin
								oe_r <= 1'b0;
								st_r <= S_WBYTE;
							end
						end
					end
					S_RBYTE: begin
						if (scl_rise) begin
							bit_r <= bit_r + 4'd1;
						end else if (scl_fall) begin
							if (bit_r == 4'd8) begin
								bit_r <= '0;
								oe_r  <= 1'b0;
								st_r  <= S_RACK;
							end else begin
								oe_r <= ~tx_r[3'(4'd7 - bit_r)];
							end
						end
					end
					S_RACK: begin
						if (scl_rise) begin
							if (sda_s) begin
								st_r <= S_IDLE;
							end else begin
								if (!byte_r[2]) byte_r <= byte_r + 3'd1;
								st_r <= S_RNEXT;
							end
						end
					end
					S_RNEXT: begin
						if (scl_fall) begin
							tx_r <= tx_sel;
							oe_r <= ~tx_sel[7];
							st_r <= S_RBYTE;
						end
					end
					default: st_r <= S_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Command interpreter
	// ----------------------------------------------------------------
	wire win_open = (win_r < CNT_W'(WINDOW_CYCLES));
	wire is_read  = (cmd_r[7:5] == GRP_READ);
	wire is_write = (cmd_r[7:5] == GRP_WRITE);
	wire take     = go_r & ~busy;

	assign mif.we    = take & session_r & is_write;
	assign mif.addr  = cmd_r[4:0];
	assign mif.wdata = {dhi_r, dlo_r};

	// Power-on window counter, saturating once the window closes.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			win_r <= '0;
		end else if (CE && win_open) begin
			win_r <= win_r + CNT_W'(1);
		end
	end

	// Decodes a completed message and keeps the session, result and fetch data.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			session_r      <= 1'b0;
			busy_r         <= '0;
			result_r       <= RES_BUSY;
			cfg_err_r      <= 1'b0;
			rd_pend_r      <= 1'b0;
			rdata_r        <= '0;
			active_addr_r  <= DEF_ADDR;
			pending_addr_r <= DEF_ADDR;
		end else if (CE) begin
			if (busy) begin
				busy_r <= busy_r - CNT_W'(1);
				if (busy_r == CNT_W'(1) && rd_pend_r) begin
					rdata_r   <= mif.rdata;
					rd_pend_r <= 1'b0;
				end
			end
			if (take && !session_r) begin
				if (cmd_r == CMD_ENTER && win_open) begin
					session_r <= 1'b1;
					result_r  <= RES_ACK;
					cfg_err_r <= 1'b0;
					busy_r    <= CNT_W'(RESP_CYCLES);
				end
			end else if (take) begin
				busy_r    <= CNT_W'(RESP_CYCLES);
				result_r  <= RES_ACK;
				cfg_err_r <= 1'b0;
				if (is_read) begin
					rd_pend_r <= 1'b1;
				end else if (is_write) begin
					busy_r <= CNT_W'(WRITE_CYCLES);
					if (cmd_r[4:0] == ADDR_WORD) pending_addr_r <= dlo_r[6:0];
				end else if (cmd_r == CMD_REV) begin
					rdata_r <= REVISION;
				end else if (cmd_r == CMD_LEAVE) begin
					session_r     <= 1'b0;
					active_addr_r <= pending_addr_r;
					busy_r        <= '0;
				end else if (cmd_r != CMD_ENTER) begin
					result_r  <= RES_NACK;
					cfg_err_r <= 1'b1;
				end
			end
		end
	end

	cfg_mem #(
		.AW       (MEM_AW),
		.DW       (MEM_DW),
		.RST_ADDR (ADDR_WORD),
		.RST_VAL  (ADDR_WORD_RST)
	) u_mem (
		.clk   (MCLK),
		.rst_n (RST_N),
		.ce    (CE),
		.port  (mif.mem)
	);

	// Open-drain data pin: only ever pulled low.
	assign SDA_OUT        = 1'b0;
	assign SDA_OE         = oe_r;
	assign CONFIG_SESSION = session_r;
	assign BUS_ADDR       = active_addr_r;

endmodule : cfg_cmd_top

// ===== cfg_cmd_monitor.sv
`timescale 1ns/1ns
module cfg_cmd_monitor
	import cfg_pkg::*;
#(
	parameter int WINDOW_CYCLES = WINDOW_CYC
)(
	input wire logic       MCLK,
	input wire logic       RST_N,
	input wire logic       CE,
	input wire logic       SCL,
	input wire logic       SDA_IN,
	input wire logic [2:0] MEM_FAULT,
	input wire logic       SDA_OUT,
	input wire logic       SDA_OE,
	input wire logic       CONFIG_SESSION,
	input wire logic [6:0] BUS_ADDR
);
	// --------
	// Checks
	// --------
	logic [19:0] age_r;
	// Counts enabled cycles since reset release, saturating.
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) age_r <= 20'h0_0000;
		else if (CE && age_r != 20'hF_FFFF) age_r <= age_r + 20'h0_0001;
	end
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence s_stop; SCL && SDA_IN; endsequence
	sequence s_hold; SDA_OE [*4]; endsequence
	property p_open_drain; SDA_OUT == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("SDA driven high");
	property p_reset_addr; $rose(RST_N) |-> BUS_ADDR == 7'h28; endproperty
	a_reset_addr: assert property (p_reset_addr) else $error("bad reset address");
	property p_addr_hold; $changed(BUS_ADDR) |-> !CONFIG_SESSION; endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("address moved in session");
	property p_window; $rose(CONFIG_SESSION) |-> age_r <= WINDOW_CYCLES; endproperty
	a_window: assert property (p_window) else $error("late session entry");
	property p_oe_scl_low; $changed(SDA_OE) |-> !SCL; endproperty
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("SDA moved with SCL high");
	property p_oe_stands; $rose(SDA_OE) |-> s_hold; endproperty
	a_oe_stands: assert property (p_oe_stands) else $error("SDA pull too short");
	property p_enter_stop; $rose(CONFIG_SESSION) |-> s_stop; endproperty
	a_enter_stop: assert property (p_enter_stop) else $error("entry before frame end");
	property p_leave_stop; $fell(CONFIG_SESSION) |-> s_stop; endproperty
	a_leave_stop: assert property (p_leave_stop) else $error("leave before frame end");
endmodule : cfg_cmd_monitor

bind cfg_cmd_top cfg_cmd_monitor #(.WINDOW_CYCLES(WINDOW_CYCLES)) cfg_cmd_monitor_inst (
	.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .SCL(SCL), .SDA_IN(SDA_IN),
	.MEM_FAULT(MEM_FAULT), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
	.CONFIG_SESSION(CONFIG_SESSION), .BUS_ADDR(BUS_ADDR)
);

// ===== cfg_host_model.sv
`timescale 1ns/1ns
// Bus master that talks to the sensor; moves only on falling clock edges.
module cfg_host_model (
	input  wire logic clk,
	input  wire logic SDA_OE,
	input  wire logic SDA_OUT,
	output logic      SCL,
	output logic      SDA_IN
);
	logic        sda_drv = 1'b1;
	logic        acked   = 1'b0;
	logic [23:0] rx      = 24'h00_0000;
	// The wire is pulled up unless either party pulls it low.
	assign SDA_IN = sda_drv & (SDA_OE ? SDA_OUT : 1'b1);
	initial SCL = 1'b1;
	// One SCL phase lasts four clock cycles.
	task automatic phase;
		repeat (4) @(negedge clk);
	endtask : phase
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		phase();
		SCL = 1'b1;
		phase();
		r = SDA_IN;
		SCL = 1'b0;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] w, input logic last, output logic [7:0] r, output logic nak);
		for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
		bit_io(last, nak);
	endtask : byte_io
	task automatic start;
		phase();
		sda_drv = 1'b0;
		phase();
		SCL = 1'b0;
	endtask : start
	task automatic stop;
		sda_drv = 1'b0;
		phase();
		SCL = 1'b1;
		phase();
		sda_drv = 1'b1;
		phase();
	endtask : stop
	// Sends one four-byte message; acked is set when every byte was acknowledged.
	task automatic send(input logic [7:0] a, c, h, l);
		logic [7:0] r;
		logic [3:0] n;
		start();
		byte_io(a, 1'b1, r, n[0]);
		byte_io(c, 1'b1, r, n[1]);
		byte_io(h, 1'b1, r, n[2]);
		byte_io(l, 1'b1, r, n[3]);
		stop();
		acked = (n == 4'h0);
	endtask : send
	// Reads response, data high and data low, refusing the last byte.
	task automatic fetch(input logic [7:0] a);
		logic [7:0] r;
		logic       n;
		start();
		byte_io(a, 1'b1, r, n);
		acked = !n;
		for (int k = 0; k < 3; k++) begin
			byte_io(8'hFF, k == 2, r, n);
			rx = {rx[15:0], r};
		end
		stop();
	endtask : fetch
endmodule : cfg_host_model

// ===== test_sensor_config_command_mode.sv
`timescale 1ns/1ns
module test_sensor_config_command_mode;
	localparam int WIN = 400;
	localparam int WR  = 200;
	localparam int RSP = 20;
	logic       MCLK = 1'b0;
	logic       RST_N = 1'b0;
	logic       CE = 1'b1;
	logic [2:0] MEM_FAULT = 3'h0;
	logic       SCL, SDA_IN, SDA_OUT, SDA_OE, CONFIG_SESSION;
	logic [6:0] BUS_ADDR;
	int         fail_count = 0;
	int         tests_run = 0;
	int         cycles = 0;
	logic [23:0] d;

	cfg_cmd_top #(.WINDOW_CYCLES(WIN), .WRITE_CYCLES(WR), .RESP_CYCLES(RSP)) cfg_cmd_top_inst (
		.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .SCL(SCL), .SDA_IN(SDA_IN), .MEM_FAULT(MEM_FAULT),
		.SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CONFIG_SESSION(CONFIG_SESSION), .BUS_ADDR(BUS_ADDR));
	cfg_host_model cfg_host_model_inst (.clk(MCLK), .SDA_OE(SDA_OE), .SDA_OUT(SDA_OUT), .SCL(SCL), .SDA_IN(SDA_IN));

	// Clock and cycle ceiling.
	initial forever #20 MCLK = ~MCLK;
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic msg(input logic [7:0] a, c, h, l, input int w);
		cfg_host_model_inst.send(a, c, h, l);
		repeat (w) @(negedge MCLK);
	endtask : msg
	task automatic fe(input logic [7:0] a);
		cfg_host_model_inst.fetch(a);
		d = cfg_host_model_inst.rx;
	endtask : fe
	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done
	task automatic t_enter;
		check("reset address", 24'h28, BUS_ADDR);
		msg(8'h50, 8'hA0, 8'h00, 8'h00, RSP + 10);
		check("enter acked", 24'h1, cfg_host_model_inst.acked);
		fe(8'h51);
		check("enter response", 24'h81, d[23:16]);
		check("session flag", 24'h1, CONFIG_SESSION);
		msg(8'h50, 8'h1C, 8'h00, 8'h00, RSP + 10);
		fe(8'h51);
		check("address word", 24'h81_0028, d);
		done("enter");
	endtask : t_enter
	task automatic t_diag;
		MEM_FAULT = 3'h5;
		msg(8'h50, 8'hB0, 8'h00, 8'h00, RSP + 10);
		fe(8'h51);
		check("revision", 24'h95_0001, d);
		MEM_FAULT = 3'h2;
		msg(8'h50, 8'h60, 8'h00, 8'h00, RSP + 10);
		fe(8'h51);
		check("unknown command", 24'hAA, d[23:16]);
		MEM_FAULT = 3'h0;
		msg(8'h52, 8'hA0, 8'h00, 8'h00, RSP + 10);
		check("foreign address", 24'h0, cfg_host_model_inst.acked);
		done("diag");
	endtask : t_diag
	task automatic t_write;
		msg(8'h50, 8'h5C, 8'h00, 8'h31, 0);
		// Freeze the block past the write time, so the fetch must still see busy.
		CE = 1'b0;
		repeat (WR + 100) @(negedge MCLK);
		CE = 1'b1;
		fe(8'h51);
		check("write busy", 24'h80, d[23:16]);
		repeat (WR) @(negedge MCLK);
		fe(8'h51);
		check("write done", 24'h81, d[23:16]);
		check("address held", 24'h28, BUS_ADDR);
		msg(8'h50, 8'h1C, 8'h00, 8'h00, RSP + 10);
		fe(8'h51);
		check("address readback", 24'h81_0031, d);
		done("write");
	endtask : t_write
	task automatic t_leave;
		msg(8'h50, 8'h80, 8'h00, 8'h00, RSP + 10);
		check("session ended", 24'h0, CONFIG_SESSION);
		check("new address", 24'h31, BUS_ADDR);
		fe(8'h63);
		check("normal fetch", 24'h140, {cfg_host_model_inst.acked, d[23:16]});
		fe(8'h51);
		check("old address", 24'h0, cfg_host_model_inst.acked);
		msg(8'h62, 8'hA0, 8'h00, 8'h00, RSP + 10);
		check("late entry", 24'h0, CONFIG_SESSION);
		done("leave");
	endtask : t_leave
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	// Reset for two cycles, then the scenarios in order.
	initial begin
		repeat (2) @(negedge MCLK);
		RST_N = 1'b1;
		t_enter();
		t_diag();
		t_write();
		t_leave();
		end_of_test();
	end
endmodule : test_sensor_config_command_mode
